// ### hdl/ppc_cfg.svh
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// ==========================================================
// Register byte addresses (index times four)
`define PPC_ADR_W 8
`define PPC_OFS_PORT5_DATA 8'h14
`define PPC_OFS_PORT6_DATA 8'h18
`define PPC_OFS_IRQ_FLAG 8'h3C
`define PPC_OFS_PORT5_DIR 8'h54
`define PPC_OFS_PORT6_DIR 8'h58
`define PPC_OFS_PULL_DOWN 8'h6C
`define PPC_OFS_OPEN_DRAIN 8'h70
`define PPC_OFS_PULL_HIGH 8'h74
`define PPC_OFS_WDT_CTRL 8'h78
`define PPC_OFS_IRQ_MASK 8'h7C
`define PPC_OFS_CORE_CTRL 8'h80

// ==========================================================
// Reset values
`define PPC_RST_DATA 8'h00
`define PPC_RST_DIR 8'hFF
`define PPC_RST_PULL_DOWN 8'hFF
`define PPC_RST_OPEN_DRAIN 8'h00
`define PPC_RST_PULL_HIGH 8'hFF
`define PPC_RST_WDT_CTRL 8'h80
`define PPC_RST_IRQ_MASK 3'h0

// ==========================================================
// Field positions
`define PPC_WDT_EN_BIT 7
`define PPC_EXT_SEL_BIT 6
`define PPC_ROPT_BIT 4
`define PPC_IRQ_TIMER 0
`define PPC_IRQ_CHANGE 1
`define PPC_IRQ_EXT 2
`define PPC_CMD_IRQ_ON_BIT 0
`define PPC_CMD_IRQ_OFF_BIT 1
`define PPC_CMD_SLEEP_BIT 2
`define PPC_WDT_MASK 8'hD0
`define PPC_P5_MASK 8'h0F

// ==========================================================
// Widths and vector
`define PPC_P5_W 4
`define PPC_P6_W 8
`define PPC_SYNC_W 12
`define PPC_IRQ_W 3
`define PPC_IRQ_VECTOR 10'h008

`endif

// ### hdl/ppc_pkg.sv
package ppc_pkg;

    typedef enum logic [1:0] {
        PPC_RUN = 2'b00,
        PPC_SLEEP = 2'b01,
        PPC_WAKE = 2'b11
    } ppc_state_t;

    typedef logic [7:0] ppc_byte_t;

endpackage

// ### hdl/ppc_sync.sv
`timescale 1ns/1ps
`include "ppc_cfg.svh"

module ppc_sync
    import ppc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [`PPC_SYNC_W-1:0] async_in,
    output logic [`PPC_SYNC_W-1:0] sync_out
);

    logic [`PPC_SYNC_W-1:0] meta_reg;

    // ==========================================================
    // Two stages; the first is read by the second only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ### hdl/ppc_top.sv
`timescale 1ns/1ps
`include "ppc_cfg.svh"

// Operation
// - Open-drain bit one makes port6 pin open-drain
// - Pull-high bit zero enables port6 pull-up
// - Pull-downs on port5 0-2, port6 0-3
// - Pull-down bit zero enables pull-down
// - Per-pin direction; data and direction readable
// - Direction one is input, zero drives
// - Watchdog control bit7 enables watchdog
// - Bit6 selects port6 pin0 as interrupt
// - Select zero blocks external interrupt path
// - Select one: data read shows pin level
// - Bit4 enables resistor-option reads on port5
// - Option read: fitted resistor zero, absent one
// - Port6 change raises interrupt or wake
// - Hardware sets flags, software only clears
// - Mask bits enable timer, change, external
// - Flag read returns flags AND mask
// - Global enable set and cleared by command
// - Change wake: vector 008H or next instruction

module ppc_top
    import ppc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PPC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [`PPC_P5_W-1:0] port5_pin_in,
    output logic [`PPC_P5_W-1:0] port5_pin_out,
    output logic [`PPC_P5_W-1:0] port5_pin_oe_n,
    output logic [2:0] port5_pulldown_en,
    input wire logic [`PPC_P6_W-1:0] port6_pin_in,
    output logic [`PPC_P6_W-1:0] port6_pin_out,
    output logic [`PPC_P6_W-1:0] port6_pin_oe_n,
    output logic [`PPC_P6_W-1:0] port6_pullup_en,
    output logic [3:0] port6_pulldown_en,
    input wire logic timer_overflow,
    input wire logic irq_ack,
    output logic watchdog_enable,
    output logic timer_overflow_irq_en,
    output logic irq_req,
    output logic [9:0] irq_vector,
    output logic sleeping,
    output logic wake
);

    // ==========================================================
    // Decode helpers
    function automatic logic reg_hit(input logic [`PPC_ADR_W-1:0] adr,
                                     input logic [`PPC_ADR_W-1:0] ofs);
        reg_hit = (adr == ofs);
    endfunction

    logic [`PPC_P5_W-1:0] port5_data_reg;
    logic [`PPC_P6_W-1:0] port6_data_reg;
    logic [`PPC_P5_W-1:0] port5_dir_reg;
    logic [`PPC_P6_W-1:0] port6_dir_reg;
    ppc_byte_t pull_down_ctrl_reg;
    ppc_byte_t open_drain_ctrl_reg;
    ppc_byte_t pull_high_ctrl_reg;
    ppc_byte_t watchdog_pin_option_ctrl_reg;
    logic [`PPC_IRQ_W-1:0] interrupt_enable_mask_reg;
    logic [`PPC_IRQ_W-1:0] irq_flag_reg;
    logic [`PPC_P6_W-1:0] port6_snap_reg;
    logic ext_pin_prev_reg;
    logic global_irq_en_reg;
    ppc_state_t state_reg;
    ppc_state_t state_next;
    logic [`PPC_SYNC_W-1:0] pins_sync;
    logic [`PPC_P5_W-1:0] p5_sync;
    logic [`PPC_P6_W-1:0] p6_sync;
    logic bus_req;
    logic bus_wr;
    logic bus_rd_done;
    logic [31:0] rd_data;
    logic [`PPC_P5_W-1:0] p5_read;
    logic [`PPC_P6_W-1:0] p6_read;
    logic [`PPC_IRQ_W-1:0] flag_set;
    logic [`PPC_IRQ_W-1:0] flag_keep;
    logic [`PPC_IRQ_W-1:0] flag_pending;
    logic ext_sel;
    logic ropt_en;
    logic change_seen;
    logic ext_fall;

    // ==========================================================
    // Pin synchronisers
    ppc_sync u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .async_in({port6_pin_in, port5_pin_in}),
        .sync_out(pins_sync)
    );

    assign p5_sync = pins_sync[`PPC_P5_W-1:0];
    assign p6_sync = pins_sync[`PPC_SYNC_W-1:`PPC_P5_W];
    assign ext_sel = watchdog_pin_option_ctrl_reg[`PPC_EXT_SEL_BIT];
    assign ropt_en = watchdog_pin_option_ctrl_reg[`PPC_ROPT_BIT];

    // ==========================================================
    // Wishbone slave: ack one cycle after request, write on ack edge
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_wr = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign bus_rd_done = bus_req && !wb_we_i && wb_ack_o;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // ==========================================================
    // Read view of the ports
    always_comb begin
        p5_read = (port5_dir_reg & p5_sync) | (~port5_dir_reg & port5_data_reg);
        p6_read = (port6_dir_reg & p6_sync) | (~port6_dir_reg & port6_data_reg);
        if (ropt_en) begin
            p5_read[1:0] = p5_sync[1:0];
        end
        if (ext_sel) begin
            p6_read[0] = p6_sync[0];
        end
    end

    // Unmapped addresses read zero and ignore writes
    always_comb begin
        rd_data = 32'h0000_0000;
        case (1'b1)
            reg_hit(wb_adr_i, `PPC_OFS_PORT5_DATA): rd_data[3:0] = p5_read;
            reg_hit(wb_adr_i, `PPC_OFS_PORT6_DATA): rd_data[7:0] = p6_read;
            reg_hit(wb_adr_i, `PPC_OFS_IRQ_FLAG): begin
                rd_data[2:0] = irq_flag_reg & interrupt_enable_mask_reg;
            end
            reg_hit(wb_adr_i, `PPC_OFS_PORT5_DIR): rd_data[3:0] = port5_dir_reg;
            reg_hit(wb_adr_i, `PPC_OFS_PORT6_DIR): rd_data[7:0] = port6_dir_reg;
            reg_hit(wb_adr_i, `PPC_OFS_PULL_DOWN): begin
                rd_data[7:0] = pull_down_ctrl_reg;
            end
            reg_hit(wb_adr_i, `PPC_OFS_OPEN_DRAIN): begin
                rd_data[7:0] = open_drain_ctrl_reg;
            end
            reg_hit(wb_adr_i, `PPC_OFS_PULL_HIGH): begin
                rd_data[7:0] = pull_high_ctrl_reg;
            end
            reg_hit(wb_adr_i, `PPC_OFS_WDT_CTRL): begin
                rd_data[7:0] = watchdog_pin_option_ctrl_reg;
            end
            reg_hit(wb_adr_i, `PPC_OFS_IRQ_MASK): begin
                rd_data[2:0] = interrupt_enable_mask_reg;
            end
            reg_hit(wb_adr_i, `PPC_OFS_CORE_CTRL): begin
                rd_data[0] = global_irq_en_reg;
                rd_data[1] = (state_reg == PPC_SLEEP);
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            port5_data_reg <= 4'(`PPC_RST_DATA);
            port6_data_reg <= `PPC_RST_DATA;
            port5_dir_reg <= 4'(`PPC_RST_DIR);
            port6_dir_reg <= `PPC_RST_DIR;
            pull_down_ctrl_reg <= `PPC_RST_PULL_DOWN;
            open_drain_ctrl_reg <= `PPC_RST_OPEN_DRAIN;
            pull_high_ctrl_reg <= `PPC_RST_PULL_HIGH;
            watchdog_pin_option_ctrl_reg <= `PPC_RST_WDT_CTRL;
            interrupt_enable_mask_reg <= `PPC_RST_IRQ_MASK;
        end else if (ce && bus_wr) begin
            if (reg_hit(wb_adr_i, `PPC_OFS_PORT5_DATA)) begin
                port5_data_reg <= wb_dat_i[3:0];
            end
            if (reg_hit(wb_adr_i, `PPC_OFS_PORT6_DATA)) begin
                port6_data_reg <= wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `PPC_OFS_PORT5_DIR)) begin
                port5_dir_reg <= wb_dat_i[3:0];
            end
            if (reg_hit(wb_adr_i, `PPC_OFS_PORT6_DIR)) begin
                port6_dir_reg <= wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `PPC_OFS_PULL_DOWN)) begin
                pull_down_ctrl_reg <= wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `PPC_OFS_OPEN_DRAIN)) begin
                open_drain_ctrl_reg <= wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `PPC_OFS_PULL_HIGH)) begin
                pull_high_ctrl_reg <= wb_dat_i[7:0];
            end
            if (reg_hit(wb_adr_i, `PPC_OFS_WDT_CTRL)) begin
                watchdog_pin_option_ctrl_reg <= wb_dat_i[7:0] & `PPC_WDT_MASK;
            end
            if (reg_hit(wb_adr_i, `PPC_OFS_IRQ_MASK)) begin
                interrupt_enable_mask_reg <= wb_dat_i[2:0];
            end
        end
    end

    // ==========================================================
    // Pin drivers; output enables are active low
    genvar gi;
    generate
        for (gi = 0; gi < `PPC_P6_W; gi++) begin : g_p6
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    port6_pin_out[gi] <= 1'b0;
                    port6_pin_oe_n[gi] <= 1'b1;
                end else if (ce) begin
                    port6_pin_out[gi] <= port6_data_reg[gi];
                    // Open drain only ever pulls low
                    port6_pin_oe_n[gi] <= port6_dir_reg[gi]
                        || (open_drain_ctrl_reg[gi] && port6_data_reg[gi])
                        || (gi == 0 && ext_sel);
                end
            end
        end
        for (gi = 0; gi < `PPC_P5_W; gi++) begin : g_p5
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    port5_pin_out[gi] <= 1'b0;
                    port5_pin_oe_n[gi] <= 1'b1;
                end else if (ce) begin
                    port5_pin_out[gi] <= port5_data_reg[gi];
                    port5_pin_oe_n[gi] <= port5_dir_reg[gi];
                end
            end
        end
    endgenerate

    // Resistor, watchdog and timer-enable outputs; bit 3 of the pull-down byte has no pin
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            port6_pullup_en <= '0;
            port5_pulldown_en <= '0;
            port6_pulldown_en <= '0;
            watchdog_enable <= 1'b0;
            timer_overflow_irq_en <= 1'b0;
        end else if (ce) begin
            port6_pullup_en <= ~pull_high_ctrl_reg;
            port5_pulldown_en <= ~pull_down_ctrl_reg[2:0];
            port6_pulldown_en <= ~pull_down_ctrl_reg[7:4];
            watchdog_enable <= watchdog_pin_option_ctrl_reg[`PPC_WDT_EN_BIT];
            timer_overflow_irq_en <= interrupt_enable_mask_reg[`PPC_IRQ_TIMER];
        end
    end

    // ==========================================================
    // Event detection
    assign change_seen = (p6_sync != port6_snap_reg);
    assign ext_fall = ext_sel && ext_pin_prev_reg && !p6_sync[0];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            port6_snap_reg <= '0;
            ext_pin_prev_reg <= 1'b1;
        end else if (ce) begin
            ext_pin_prev_reg <= p6_sync[0];
            if (bus_rd_done && reg_hit(wb_adr_i, `PPC_OFS_PORT6_DATA)) begin
                port6_snap_reg <= p6_sync;
            end
        end
    end

    // Writing zero clears a flag; a same-cycle event wins
    always_comb begin
        flag_set = '0;
        flag_set[`PPC_IRQ_TIMER] = timer_overflow;
        flag_set[`PPC_IRQ_CHANGE] = change_seen;
        flag_set[`PPC_IRQ_EXT] = ext_fall;
        flag_keep = irq_flag_reg;
        if (bus_wr && reg_hit(wb_adr_i, `PPC_OFS_IRQ_FLAG)) begin
            flag_keep = irq_flag_reg & wb_dat_i[2:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_flag_reg <= '0;
        end else if (ce) begin
            irq_flag_reg <= flag_keep | flag_set;
        end
    end

    assign flag_pending = irq_flag_reg & interrupt_enable_mask_reg;

    // ==========================================================
    // Global enable and sleep control
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            global_irq_en_reg <= 1'b0;
        end else if (ce) begin
            if (bus_wr && reg_hit(wb_adr_i, `PPC_OFS_CORE_CTRL)
                && wb_dat_i[`PPC_CMD_IRQ_OFF_BIT]) begin
                global_irq_en_reg <= 1'b0;
            end else if (bus_wr && reg_hit(wb_adr_i, `PPC_OFS_CORE_CTRL)
                && wb_dat_i[`PPC_CMD_IRQ_ON_BIT]) begin
                global_irq_en_reg <= 1'b1;
            end else if (irq_ack) begin
                global_irq_en_reg <= 1'b0;
            end
        end
    end

    // Only the change source wakes; the watchdog reset path lies outside
    always_comb begin
        case (state_reg)
            PPC_RUN: begin
                if (bus_wr && reg_hit(wb_adr_i, `PPC_OFS_CORE_CTRL)
                    && wb_dat_i[`PPC_CMD_SLEEP_BIT]) begin
                    state_next = PPC_SLEEP;
                end else begin
                    state_next = PPC_RUN;
                end
            end
            PPC_SLEEP: begin
                if (flag_pending[`PPC_IRQ_CHANGE]) begin
                    state_next = PPC_WAKE;
                end else begin
                    state_next = PPC_SLEEP;
                end
            end
            PPC_WAKE: state_next = PPC_RUN;
            default: state_next = PPC_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= PPC_RUN;
            sleeping <= 1'b0;
            wake <= 1'b0;
            irq_req <= 1'b0;
            irq_vector <= 10'h000;
        end else if (ce) begin
            state_reg <= state_next;
            sleeping <= (state_next == PPC_SLEEP);
            wake <= (state_next == PPC_WAKE);
            // Without global enable the core resumes at the next step
            irq_req <= global_irq_en_reg && (|flag_pending)
                && (state_reg != PPC_SLEEP);
            irq_vector <= (global_irq_en_reg && (|flag_pending))
                ? `PPC_IRQ_VECTOR : 10'h000;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_open_drain;
        ce |=> ((~port6_pin_oe_n) & port6_pin_out
            & $past(open_drain_ctrl_reg)) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

    property p_pullup;
        ce |=> port6_pullup_en == ~$past(pull_high_ctrl_reg);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up enable does not follow control");

    property p_pulldown;
        ce |=> {port6_pulldown_en, port5_pulldown_en}
            == ~{$past(pull_down_ctrl_reg[7:4]), $past(pull_down_ctrl_reg[2:0])};
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pull-down enable does not follow control");

    property p_input_dir;
        ce |=> ((~port5_pin_oe_n) & $past(port5_dir_reg)) == 4'h0;
    endproperty
    a_input_dir: assert property (p_input_dir)
        else $error("input pin driven");

    property p_ext_block;
        ce && !ext_sel && !irq_flag_reg[`PPC_IRQ_EXT]
            |=> !irq_flag_reg[`PPC_IRQ_EXT];
    endproperty
    a_ext_block: assert property (p_ext_block)
        else $error("external flag set while path blocked");

    property p_change_flag;
        ce && change_seen |=> irq_flag_reg[`PPC_IRQ_CHANGE];
    endproperty
    a_change_flag: assert property (p_change_flag)
        else $error("change flag lost");

    property p_flag_read;
        ce && bus_req && !wb_ack_o && !wb_we_i
            && wb_adr_i == `PPC_OFS_IRQ_FLAG
            |=> wb_ack_o && wb_dat_o[2:0]
                == $past(irq_flag_reg & interrupt_enable_mask_reg);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("flag read not masked");

    property p_irq_gate;
        ce && !global_irq_en_reg |=> !irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without global enable");

    property p_wake;
        ce && state_reg == PPC_SLEEP && flag_pending[`PPC_IRQ_CHANGE]
            |=> wake ##1 (!wake || !ce);
    endproperty
    a_wake: assert property (p_wake)
        else $error("change did not wake");

    c_wake: cover property (ce && wake);
    c_ext: cover property (ce && ext_fall);
    c_irq: cover property (irq_req && irq_vector == `PPC_IRQ_VECTOR);
    c_ropt: cover property (bus_rd_done && ropt_en);

endmodule

// ### testbench/ppc_pin_model.sv
`timescale 1ns/1ps

module ppc_pin_model (
    input wire logic sys_clk,
    input wire logic [11:0] drv,
    input wire logic [11:0] oe_n,
    input wire logic [11:0] pu,
    input wire logic [11:0] pd,
    input wire logic [11:0] ext_en,
    input wire logic [11:0] ext_val,
    input wire logic [1:0] rex_fitted,
    output logic [11:0] pin
);
    logic [11:0] last_reg = 12'h000;

    // ==========================================================
    // Pin resolution
    // Undriven lines flip, so a stale level never reads as valid
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (!oe_n[i]) begin
                pin[i] = drv[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (i < 2) begin
                pin[i] = !rex_fitted[i];
            end else if (pu[i]) begin
                pin[i] = 1'h1;
            end else if (pd[i]) begin
                pin[i] = 1'h0;
            end else begin
                pin[i] = !last_reg[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        last_reg <= pin;
    end
endmodule

// ### testbench/tb_ppc_top.sv
`timescale 1ns/1ps
`include "ppc_cfg.svh"
`define CHK(got, exp) check_eq((got) === (exp), `__LINE__)

module tb_ppc_top import ppc_pkg::*;;
    localparam logic [7:0] a_d5 = `PPC_OFS_PORT5_DATA;
    localparam logic [7:0] a_d6 = `PPC_OFS_PORT6_DATA;
    localparam logic [7:0] a_flg = `PPC_OFS_IRQ_FLAG;
    localparam logic [7:0] a_dir5 = `PPC_OFS_PORT5_DIR;
    localparam logic [7:0] a_dir6 = `PPC_OFS_PORT6_DIR;
    localparam logic [7:0] a_pd = `PPC_OFS_PULL_DOWN;
    localparam logic [7:0] a_od = `PPC_OFS_OPEN_DRAIN;
    localparam logic [7:0] a_ph = `PPC_OFS_PULL_HIGH;
    localparam logic [7:0] a_wdt = `PPC_OFS_WDT_CTRL;
    localparam logic [7:0] a_msk = `PPC_OFS_IRQ_MASK;
    localparam logic [7:0] a_core = `PPC_OFS_CORE_CTRL;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic ce = 1'h1;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, timer_overflow = 1'h0, irq_ack = 1'h0;
    logic [3:0] port5_pin_in, port5_pin_out, port5_pin_oe_n;
    logic [2:0] port5_pulldown_en;
    logic [7:0] port6_pin_in, port6_pin_out, port6_pin_oe_n;
    logic [7:0] port6_pullup_en;
    logic [3:0] port6_pulldown_en;
    logic watchdog_enable, timer_overflow_irq_en, irq_req, sleeping, wake;
    logic [9:0] irq_vector;
    logic [11:0] ext_en = 12'hFFC, ext_val = 12'h000, pin_lvl;
    int mismatches = 0, checks_done = 0;

    assign {port6_pin_in, port5_pin_in} = pin_lvl;

    ppc_top u_ppc_top (.sys_clk, .reset, .ce, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .port5_pin_in, .port5_pin_out, .port5_pin_oe_n, .port5_pulldown_en,
        .port6_pin_in, .port6_pin_out, .port6_pin_oe_n, .port6_pullup_en,
        .port6_pulldown_en, .timer_overflow, .irq_ack, .watchdog_enable,
        .timer_overflow_irq_en, .irq_req, .irq_vector, .sleeping, .wake);

    ppc_pin_model u_ppc_pin_model (.sys_clk,
        .drv({port6_pin_out, port5_pin_out}),
        .oe_n({port6_pin_oe_n, port5_pin_oe_n}),
        .pu({port6_pullup_en, 4'h0}),
        .pd({4'h0, port6_pulldown_en, 1'h0, port5_pulldown_en}),
        .ext_en, .ext_val, .rex_fitted(2'h1), .pin(pin_lvl));

    // ==========================================================
    // Shared tasks
    task automatic check_eq(input bit ok, input int ln);
        checks_done++;
        if (!ok) begin
            mismatches++;
            $display("MISMATCH at %0t: value differs, line %0d", $time, ln);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        q = wb_dat_o[7:0];
        `CHK(wb_ack_o, 1'h1);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'h1, a, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'h0, a, 8'h00, q);
        `CHK(q, e);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rc(a_dir6, 8'hFF);
        rc(a_pd, 8'hFF);
        rc(a_od, 8'h00);
        rc(a_ph, 8'hFF);
        rc(a_wdt, 8'h80);
        rc(a_msk, 8'h00);
        rc(8'h04, 8'h00);
        `CHK(port6_pin_oe_n, 8'hFF);
        `CHK(port6_pullup_en, 8'h00);
        `CHK(watchdog_enable, 1'h1);
    endtask

    task automatic t_dir_od();
        wr(a_d6, 8'hA5);
        wr(a_dir6, 8'h00);
        wr(a_d5, 8'h05);
        wr(a_dir5, 8'h00);
        idle(2);
        `CHK(port6_pin_oe_n, 8'h00);
        `CHK(port6_pin_out, 8'hA5);
        `CHK(port5_pin_out, 4'h5);
        `CHK(port5_pin_oe_n, 4'h0);
        rc(a_d6, 8'hA5);
        wr(a_od, 8'hFF);
        idle(2);
        `CHK(port6_pin_oe_n, 8'hA5);
        rc(a_od, 8'hFF);
        wr(a_od, 8'h00);
        wr(a_dir6, 8'hFF);
        wr(a_dir5, 8'h0F);
    endtask

    task automatic t_pulls();
        wr(a_ph, 8'h0F);
        wr(a_pd, 8'h5A);
        idle(2);
        `CHK(port6_pullup_en, 8'hF0);
        `CHK(port6_pulldown_en, 4'hA);
        `CHK(port5_pulldown_en, 3'h5);
        rc(a_pd, 8'h5A);
        wr(a_ph, 8'hFF);
        wr(a_pd, 8'hFF);
    endtask

    task automatic t_wdt();
        wr(a_wdt, 8'h00);
        idle(2);
        `CHK(watchdog_enable, 1'h0);
        wr(a_wdt, 8'hFF);
        rc(a_wdt, 8'hD0);
        `CHK(watchdog_enable, 1'h1);
        wr(a_wdt, 8'h80);
    endtask

    task automatic t_ext();
        wr(a_msk, 8'h04);
        ext_val <= 12'h010;
        idle(4);
        ext_val <= 12'h000;
        idle(4);
        rc(a_flg, 8'h00);
        wr(a_dir6, 8'hFF);
        wr(a_wdt, 8'hC0);
        ext_val <= 12'h010;
        idle(4);
        rc(a_d6, 8'h01);
        ext_val <= 12'h000;
        idle(4);
        rc(a_flg, 8'h04);
        rc(a_d6, 8'h00);
        wr(a_msk, 8'h00);
        rc(a_flg, 8'h00);
        wr(a_msk, 8'h07);
        rc(a_flg, 8'h06);
        wr(a_flg, 8'h00);
        rc(a_flg, 8'h00);
        wr(a_wdt, 8'h80);
        wr(a_msk, 8'h00);
    endtask

    task automatic t_change();
        rc(a_d6, 8'h00);
        wr(a_core, 8'h01);
        wr(a_msk, 8'h02);
        idle(2);
        `CHK(irq_req, 1'h0);
        ext_val <= 12'h800;
        idle(6);
        `CHK(irq_req, 1'h1);
        `CHK(irq_vector, 10'h008);
        wr(a_flg, 8'hFF);
        rc(a_flg, 8'h02);
        rc(a_d6, 8'h80);
        wr(a_flg, 8'h00);
        rc(a_flg, 8'h00);
        `CHK(irq_req, 1'h0);
        irq_ack <= 1'h1;
        idle(1);
        irq_ack <= 1'h0;
        rc(a_core, 8'h00);
        timer_overflow <= 1'h1;
        idle(1);
        timer_overflow <= 1'h0;
        wr(a_msk, 8'h01);
        idle(1);
        `CHK(timer_overflow_irq_en, 1'h1);
        rc(a_flg, 8'h01);
    endtask

    task automatic t_sleep();
        int n;
        n = 0;
        wr(a_flg, 8'h00);
        wr(a_wdt, 8'h00);
        wr(a_msk, 8'h02);
        wr(a_core, 8'h02);
        wr(a_core, 8'h04);
        idle(2);
        `CHK(sleeping, 1'h1);
        ext_val <= 12'h000;
        while (wake !== 1'h1 && n < 10) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(wake, 1'h1);
        `CHK(irq_vector, 10'h000);
        idle(2);
        `CHK(sleeping, 1'h0);
        `CHK(irq_req, 1'h0);
    endtask

    task automatic t_ropt();
        wr(a_dir5, 8'h0F);
        wr(a_wdt, 8'h10);
        idle(3);
        rc(a_d5, 8'h02);
        wr(a_wdt, 8'h80);
        wb_sel_i <= 4'hE;
        wr(a_od, 8'h55);
        wb_sel_i <= 4'hF;
        rc(a_od, 8'h00);
        wr(a_flg, 8'h00);
        wr(a_msk, 8'h01);
        ce <= 1'h0;
        timer_overflow <= 1'h1;
        idle(2);
        ce <= 1'h1;
        timer_overflow <= 1'h0;
        rc(a_flg, 8'h00);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, sequence, hang guard
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        t_reset();
        t_dir_od();
        t_pulls();
        t_wdt();
        t_ext();
        t_change();
        t_sleep();
        t_ropt();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end
endmodule
